// ---- design/mic_defs.vh ----
// Constants of the processor interrupt controller: offsets, fields, reset values.
//
// Notes on behaviour
// - Source register read-only, synchronised, writes ignored.
// - Each request input sits at fixed bit.
// - Undefined source bits zero; software bits one.
// - Card port bit ORs four card conditions.
// - Messaging and pin requests get synchronised.
// - Pin requests edge or level; others level.
// - Asserted, normally enabled source raises normal request.
// - Masked source neither forwarded nor vectored.
// - Both enable registers clear at reset.
// - Unused enable bits stored, no effect.
// - Enables and control update on full words.
// - Fast enable like normal, drives fast request.
// - Software enable bit raises request at once.
// - Normal pending shows asserted enabled sources.
// - Normal pending unused zero, low three one.
// - Fast pending reports fast enabled sources.
// - Control bit 15 enables top-priority vectoring.
// - Control bits 11-7 select top source.
// - Control bits 6-0 vector supplied while pending.
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define MIC_OFS_SOURCE      32'h0020_0000
`define MIC_OFS_NRM_EN      32'h0020_0004
`define MIC_OFS_FST_EN      32'h0020_0008
`define MIC_OFS_NRM_PEND    32'h0020_000c
`define MIC_OFS_FST_PEND    32'h0020_0010
`define MIC_OFS_TOP_CTRL    32'h0020_0014

// ----------------------------------------------------------------------------
// Source bit positions
// ----------------------------------------------------------------------------
`define MIC_BIT_SER_RX      31
`define MIC_BIT_CARD_SENSE  30
`define MIC_BIT_SER_TX      29
`define MIC_BIT_FT_EV_HI    28
`define MIC_BIT_FT_EV_LO    26
`define MIC_BIT_FT_MISC     25
`define MIC_BIT_QUEUED_SPI  24
`define MIC_BIT_MSG         23
`define MIC_BIT_CARD_PORT   22
`define MIC_BIT_TMR_PWM     17
`define MIC_BIT_PERIODIC    16
`define MIC_BIT_KEYPAD      14
`define MIC_BIT_SER_HS      13
`define MIC_BIT_PIN_HI      12
`define MIC_BIT_PIN_LO      5
`define MIC_BIT_SOFT_HI     2
`define MIC_BIT_SOFT_LO     0

// Bits that carry a defined source, and the always-set software bits.
`define MIC_USED_MASK       32'hffc3_7fe7
`define MIC_SOFT_MASK       32'h0000_0007

// ----------------------------------------------------------------------------
// Top-priority control fields
// ----------------------------------------------------------------------------
`define MIC_CTRL_EN_BIT     15
`define MIC_CTRL_SRC_HI     11
`define MIC_CTRL_SRC_LO     7
`define MIC_CTRL_VEC_HI     6
`define MIC_CTRL_VEC_LO     0
`define MIC_CTRL_MASK       32'h0000_8fff

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MIC_RST_ENABLE      32'h0000_0000
`define MIC_RST_CTRL        32'h0000_0000
`define MIC_RST_ZERO        32'h0000_0000

`endif

// ---- design/mic_sync.v ----
// Two-stage synchroniser for asynchronous request lines.
`timescale 1ns/1ps
module mic_sync #(
   parameter WIDTH = 9
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   // ----------------------------------------------------------------------------
   // Only the second stage is visible outside.
   // ----------------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule // mic_sync

// ---- design/mic_ctrl.v ----
// Processor interrupt controller: source, enable, pending and top-priority registers.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_ctrl #(
   parameter PIN_COUNT = 8
) (
   input  wire                 clk,
   input  wire                 rst_n,
   // Register port.
   input  wire [31:0]          reg_addr,
   input  wire [31:0]          reg_wdata,
   input  wire [3:0]           reg_byte_en,
   input  wire                 reg_wr,
   input  wire                 reg_rd,
   output wire [31:0]          reg_rdata,
   // Synchronous request lines.
   input  wire                 serial_rx_ready_src,
   input  wire                 card_sense_src,
   input  wire                 serial_tx_src,
   input  wire [2:0]           frame_timer_event_srcs,
   input  wire                 frame_timer_misc_src,
   input  wire                 queued_spi_src,
   input  wire                 card_tx_done,
   input  wire                 card_rx_not_empty,
   input  wire                 card_rx_full,
   input  wire                 card_rx_error,
   input  wire                 gp_timer_pwm_src,
   input  wire                 periodic_timer_src,
   input  wire                 keypad_src,
   input  wire                 serial_handshake_change_src,
   // Asynchronous request lines.
   input  wire                 core_messaging_src,
   input  wire [PIN_COUNT-1:0] edge_pin_srcs,
   // Pin trigger control from the edge port.
   input  wire [PIN_COUNT-1:0] edge_pin_edge_sel,
   input  wire [PIN_COUNT-1:0] edge_pin_clr,
   // Core request outputs.
   output wire                 normal_irq,
   output wire                 fast_irq,
   output wire                 vector_valid,
   output wire [6:0]           vector_num
);

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------

   // A write counts only when all four byte lanes are selected.
   function is_word_write;
      input       wr;
      input [3:0] be;
      begin
         is_word_write = wr & (&be);
      end
   endfunction

   // Picks one bit of a word by its position.
   function pick_bit;
      input [31:0] word;
      input [4:0]  pos;
      begin
         pick_bit = word[pos];
      end
   endfunction

   // Masks the source word by one enable word; unused bits never pass.
   function [31:0] pend_of;
      input [31:0] src;
      input [31:0] en;
      begin
         pend_of = src & en & `MIC_USED_MASK;
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   wire [PIN_COUNT:0]   async_sync;
   wire                 msg_sync;
   wire [PIN_COUNT-1:0] pin_sync;
   wire [PIN_COUNT-1:0] pin_rise;
   wire [PIN_COUNT-1:0] pin_req;
   wire                 card_port_req;
   wire                 word_wr;
   wire [31:0]          nrm_pend_raw;
   wire [31:0]          fst_pend_raw;
   wire [4:0]           top_src_sel;
   wire                 top_active;

   reg  [PIN_COUNT-1:0] pin_prev_ff;
   reg  [PIN_COUNT-1:0] pin_latch_ff;
   reg  [PIN_COUNT-1:0] nxt_pin_latch;
   reg  [31:0]          source_ff;
   reg  [31:0]          nxt_source;
   reg  [31:0]          nrm_en_ff;
   reg  [31:0]          fst_en_ff;
   reg  [31:0]          top_ctrl_ff;
   reg  [31:0]          rdata_ff;
   reg  [31:0]          nxt_rdata;
   reg                  normal_irq_ff;
   reg                  fast_irq_ff;
   reg                  vector_valid_ff;
   reg  [6:0]           vector_num_ff;

   // ----------------------------------------------------------------------------
   // Synchronisation of the asynchronous lines
   // ----------------------------------------------------------------------------
   mic_sync #(
      .WIDTH (PIN_COUNT + 1)
   ) u_async_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({core_messaging_src, edge_pin_srcs}),
      .sync_out (async_sync)
   );

   assign msg_sync = async_sync[PIN_COUNT];
   assign pin_sync = async_sync[PIN_COUNT-1:0];

   // ----------------------------------------------------------------------------
   // Edge or level handling of the pin requests
   // ----------------------------------------------------------------------------
   assign pin_rise = pin_sync & ~pin_prev_ff;

   // A new edge in the same cycle as a clear keeps the request set.
   always @* begin
      nxt_pin_latch = (pin_latch_ff & ~edge_pin_clr) | (pin_rise & edge_pin_edge_sel);
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_ff  <= {PIN_COUNT{1'b0}};
         pin_latch_ff <= {PIN_COUNT{1'b0}};
      end else begin
         pin_prev_ff  <= pin_sync;
         pin_latch_ff <= nxt_pin_latch;
      end
   end

   // Level pins follow the pin; edge pins show the latched event.
   assign pin_req = (edge_pin_edge_sel & pin_latch_ff) | (~edge_pin_edge_sel & pin_sync);

   // ----------------------------------------------------------------------------
   // Source assembly
   // ----------------------------------------------------------------------------
   assign card_port_req = card_tx_done | card_rx_not_empty | card_rx_full | card_rx_error;

   always @* begin
      nxt_source = `MIC_RST_ZERO;
      nxt_source[`MIC_BIT_SER_RX]     = serial_rx_ready_src;
      nxt_source[`MIC_BIT_CARD_SENSE] = card_sense_src;
      nxt_source[`MIC_BIT_SER_TX]     = serial_tx_src;
      nxt_source[`MIC_BIT_FT_EV_HI:`MIC_BIT_FT_EV_LO] = frame_timer_event_srcs;
      nxt_source[`MIC_BIT_FT_MISC]    = frame_timer_misc_src;
      nxt_source[`MIC_BIT_QUEUED_SPI] = queued_spi_src;
      nxt_source[`MIC_BIT_MSG]        = msg_sync;
      nxt_source[`MIC_BIT_CARD_PORT]  = card_port_req;
      nxt_source[`MIC_BIT_TMR_PWM]    = gp_timer_pwm_src;
      nxt_source[`MIC_BIT_PERIODIC]   = periodic_timer_src;
      nxt_source[`MIC_BIT_KEYPAD]     = keypad_src;
      nxt_source[`MIC_BIT_SER_HS]     = serial_handshake_change_src;
      nxt_source[`MIC_BIT_PIN_HI:`MIC_BIT_PIN_LO] = pin_req;
      nxt_source[`MIC_BIT_SOFT_HI:`MIC_BIT_SOFT_LO] = 3'h7;
   end

   // The source word is sampled every clock, so a read sees one stable copy.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         source_ff <= `MIC_SOFT_MASK;
      end else begin
         source_ff <= nxt_source & `MIC_USED_MASK;
      end
   end

   // ----------------------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------------------
   assign word_wr = is_word_write(reg_wr, reg_byte_en);

   // Source and pending addresses take no writes at all.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nrm_en_ff   <= `MIC_RST_ENABLE;
         fst_en_ff   <= `MIC_RST_ENABLE;
         top_ctrl_ff <= `MIC_RST_CTRL;
      end else begin
         if (word_wr && reg_addr == `MIC_OFS_NRM_EN) begin
            nrm_en_ff <= reg_wdata;
         end
         if (word_wr && reg_addr == `MIC_OFS_FST_EN) begin
            fst_en_ff <= reg_wdata;
         end
         if (word_wr && reg_addr == `MIC_OFS_TOP_CTRL) begin
            top_ctrl_ff <= reg_wdata & `MIC_CTRL_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Pending sets
   // ----------------------------------------------------------------------------
   // Unused source bits are zero, so unused enable bits cannot pass anything.
   assign nrm_pend_raw = pend_of(source_ff, nrm_en_ff);
   assign fst_pend_raw = pend_of(source_ff, fst_en_ff);

   // ----------------------------------------------------------------------------
   // Top-priority selection
   // ----------------------------------------------------------------------------
   assign top_src_sel = top_ctrl_ff[`MIC_CTRL_SRC_HI:`MIC_CTRL_SRC_LO];

   // Only a fast-enabled, asserted source can be promoted.
   assign top_active = top_ctrl_ff[`MIC_CTRL_EN_BIT] & pick_bit(fst_pend_raw, top_src_sel);

   // ----------------------------------------------------------------------------
   // Core request outputs
   // ----------------------------------------------------------------------------
   // A bit set in both enables drives both requests; nothing arbitrates here.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         normal_irq_ff   <= 1'b0;
         fast_irq_ff     <= 1'b0;
         vector_valid_ff <= 1'b0;
         vector_num_ff   <= 7'h00;
      end else begin
         normal_irq_ff   <= |nrm_pend_raw;
         fast_irq_ff     <= |fst_pend_raw;
         vector_valid_ff <= top_active;
         if (top_active) begin
            vector_num_ff <= top_ctrl_ff[`MIC_CTRL_VEC_HI:`MIC_CTRL_VEC_LO];
         end else begin
            vector_num_ff <= 7'h00;
         end
      end
   end

   assign normal_irq   = normal_irq_ff;
   assign fast_irq     = fast_irq_ff;
   assign vector_valid = vector_valid_ff;
   assign vector_num   = vector_num_ff;

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   always @* begin
      nxt_rdata = `MIC_RST_ZERO;
      case (reg_addr)
         `MIC_OFS_SOURCE: begin
            nxt_rdata = source_ff;
         end
         `MIC_OFS_NRM_EN: begin
            nxt_rdata = nrm_en_ff;
         end
         `MIC_OFS_FST_EN: begin
            nxt_rdata = fst_en_ff;
         end
         `MIC_OFS_NRM_PEND: begin
            nxt_rdata = nrm_pend_raw | `MIC_SOFT_MASK;
         end
         `MIC_OFS_FST_PEND: begin
            nxt_rdata = fst_pend_raw | `MIC_SOFT_MASK;
         end
         `MIC_OFS_TOP_CTRL: begin
            nxt_rdata = top_ctrl_ff;
         end
         default: begin
            nxt_rdata = `MIC_RST_ZERO;
         end
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= `MIC_RST_ZERO;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= `MIC_RST_ZERO;
      end
   end

   assign reg_rdata = rdata_ff;

endmodule // mic_ctrl

// ---- test/mic_ctrl_monitor.sv ----
// Concurrent checks of the interrupt controller at its ports.
`timescale 1ns/1ps
`include "mic_defs.vh"
module mic_ctrl_monitor (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [3:0]  reg_byte_en,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        normal_irq,
   input wire logic        fast_irq,
   input wire logic        vector_valid,
   input wire logic [6:0]  vector_num
);
   // ---------------------------------------------------------------
   // Shadow registers, updated by full-word writes only.
   // ---------------------------------------------------------------
   logic [31:0] nen_ff;
   logic [31:0] fen_ff;
   logic [31:0] ctl_ff;
   wire         full_wr = reg_wr && reg_byte_en == 4'hf;
   wire         rd_en   = reg_rd && reg_addr == `MIC_OFS_NRM_EN;
   wire         rd_fix  = reg_rd && (reg_addr == `MIC_OFS_SOURCE || reg_addr == `MIC_OFS_NRM_PEND);
   wire         vec_on  = ctl_ff[15];
   wire [6:0]   vec_exp = ctl_ff[6:0];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nen_ff <= 32'h0;
         fen_ff <= 32'h0;
         ctl_ff <= 32'h0;
      end else if (full_wr) begin
         if (reg_addr == `MIC_OFS_NRM_EN)
            nen_ff <= reg_wdata;
         if (reg_addr == `MIC_OFS_FST_EN)
            fen_ff <= reg_wdata;
         if (reg_addr == `MIC_OFS_TOP_CTRL)
            ctl_ff <= reg_wdata & `MIC_CTRL_MASK;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   norm_req_a: assert property (|($past(nen_ff) & `MIC_SOFT_MASK) |-> normal_irq)
      else $error("normal request missing");
   fast_req_a: assert property (|($past(fen_ff) & `MIC_SOFT_MASK) |-> fast_irq)
      else $error("fast request missing");
   norm_mask_a: assert property ($past(nen_ff) == 32'h0 |-> !normal_irq)
      else $error("masked normal request");
   fast_mask_a: assert property ($past(fen_ff) == 32'h0 |-> !fast_irq)
      else $error("masked fast request");
   vec_dis_a: assert property (!$past(vec_on) |-> !vector_valid)
      else $error("vector while disabled");
   vec_num_a: assert property (vector_valid |-> vector_num == $past(vec_exp))
      else $error("wrong vector number");
   vec_fast_a: assert property (vector_valid |-> fast_irq)
      else $error("vector without fast request");
   vec_auto_a: assert property (!vector_valid |-> vector_num == 7'h0)
      else $error("vector number without vector");
   rd_en_a: assert property ($past(rd_en) |-> reg_rdata == $past(nen_ff))
      else $error("enable readback wrong");
   rd_fix_a: assert property ($past(rd_fix) |-> reg_rdata[2:0] == 3'h7 && (reg_rdata & ~`MIC_USED_MASK) == 32'h0)
      else $error("fixed bits wrong");
endmodule // mic_ctrl_monitor

bind mic_ctrl mic_ctrl_monitor mic_ctrl_monitor_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .normal_irq(normal_irq), .fast_irq(fast_irq),
   .vector_valid(vector_valid), .vector_num(vector_num));

// ---- test/mic_core_model.sv ----
// Processor core model: master of the controller's register port.
`timescale 1ns/1ps
module mic_core_model (
   input  wire logic        clk,
   output logic [31:0]      reg_addr,
   output logic [31:0]      reg_wdata,
   output logic [3:0]       reg_byte_en,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [31:0] reg_rdata
);
   initial begin
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      reg_byte_en = 4'hf;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Lane enables other than 4'hf are issued only when a test asks for them.
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_byte_en <= be;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_byte_en <= 4'hf;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] q);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      q = reg_rdata;
   endtask
endmodule // mic_core_model

// ---- test/mcu_interrupt_controller_tb_top.sv ----
// Self-checking testbench of the processor interrupt controller.
`timescale 1ns/1ps
`include "mic_defs.vh"
module mcu_interrupt_controller_tb_top;
   logic        clk, rst_n, reg_wr, reg_rd, normal_irq, fast_irq, vector_valid;
   logic [24:0] s;
   logic [7:0]  esel, eclr;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [3:0]  reg_byte_en;
   logic [6:0]  vector_num;
   int          mismatches, n_checks;
   int          pos [0:24] = '{31,30,29,26,27,28,25,24,22,22,22,22,17,16,14,13,23,5,6,7,8,9,10,11,12};

   mic_ctrl #(.PIN_COUNT(8)) mic_ctrl_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_rx_ready_src(s[0]), .card_sense_src(s[1]), .serial_tx_src(s[2]), .frame_timer_event_srcs(s[5:3]),
      .frame_timer_misc_src(s[6]), .queued_spi_src(s[7]), .card_tx_done(s[8]), .card_rx_not_empty(s[9]),
      .card_rx_full(s[10]), .card_rx_error(s[11]), .gp_timer_pwm_src(s[12]), .periodic_timer_src(s[13]),
      .keypad_src(s[14]), .serial_handshake_change_src(s[15]), .core_messaging_src(s[16]),
      .edge_pin_srcs(s[24:17]), .edge_pin_edge_sel(esel), .edge_pin_clr(eclr), .normal_irq(normal_irq),
      .fast_irq(fast_irq), .vector_valid(vector_valid), .vector_num(vector_num));
   mic_core_model mic_core_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_byte_en(reg_byte_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task rc(input logic [31:0] a, input logic [31:0] e);
      mic_core_model_i.rd(a, d);
      chk(d, e);
   endtask
   task w(input logic [31:0] a, input logic [31:0] v);
      mic_core_model_i.wr(a, v, 4'hf);
   endtask
   // Sources change on an edge, then settle through synchroniser and edge latch.
   task drv(input logic [24:0] v);
      @(posedge clk);
      s <= v;
      repeat (6) @(negedge clk);
   endtask
   task wt;
      repeat (2) @(negedge clk);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task t_reset;
      rc(`MIC_OFS_SOURCE, 32'h7);
      rc(`MIC_OFS_NRM_EN, 32'h0);
      rc(`MIC_OFS_FST_EN, 32'h0);
      rc(`MIC_OFS_NRM_PEND, 32'h7);
      rc(`MIC_OFS_FST_PEND, 32'h7);
      rc(`MIC_OFS_TOP_CTRL, 32'h0);
   endtask
   task t_map;
      for (int i = 0; i < 25; i++) begin
         drv(25'h1 << i);
         rc(`MIC_OFS_SOURCE, (32'h1 << pos[i]) | 32'h7);
      end
      drv(25'h0);
      w(`MIC_OFS_SOURCE, 32'hffff_fff8);
      w(32'h0020_0018, 32'hffff_ffff);
      rc(`MIC_OFS_SOURCE, 32'h7);
      rc(32'h0020_0018, 32'h0);
   endtask
   task t_enable;
      mic_core_model_i.wr(`MIC_OFS_NRM_EN, 32'hffff_ffff, 4'h3);
      rc(`MIC_OFS_NRM_EN, 32'h0);
      drv(25'h1ff_ffff);
      w(`MIC_OFS_NRM_EN, ~`MIC_USED_MASK);
      wt;
      chk({31'h0, normal_irq}, 32'h0);
      rc(`MIC_OFS_NRM_EN, ~`MIC_USED_MASK);
      rc(`MIC_OFS_NRM_PEND, 32'h7);
      drv(25'h1 << 13);
      w(`MIC_OFS_NRM_EN, 32'h0001_0000);
      wt;
      chk({31'h0, normal_irq}, 32'h1);
      w(`MIC_OFS_NRM_PEND, 32'h0);
      rc(`MIC_OFS_NRM_PEND, 32'h0001_0007);
      drv(25'h0);
      chk({31'h0, normal_irq}, 32'h0);
      w(`MIC_OFS_NRM_EN, 32'h0);
   endtask
   task t_soft;
      for (int k = 0; k < 3; k++) begin
         w(`MIC_OFS_NRM_EN, 32'h1 << k);
         w(`MIC_OFS_FST_EN, 32'h1 << k);
         wt;
         chk({30'h0, normal_irq, fast_irq}, 32'h3);
      end
      w(`MIC_OFS_NRM_EN, 32'h0);
      w(`MIC_OFS_FST_EN, 32'h0);
      wt;
      chk({30'h0, normal_irq, fast_irq}, 32'h0);
   endtask
   task t_vector;
      drv(25'h1 << 13);
      w(`MIC_OFS_FST_EN, 32'h0001_0000);
      w(`MIC_OFS_TOP_CTRL, 32'h0000_8820);
      mic_core_model_i.wr(`MIC_OFS_TOP_CTRL, 32'h0, 4'hc);
      rc(`MIC_OFS_TOP_CTRL, 32'h0000_8820);
      rc(`MIC_OFS_FST_PEND, 32'h0001_0007);
      chk({23'h0, fast_irq, vector_valid, vector_num}, {23'h0, 2'b11, 7'h20});
      w(`MIC_OFS_TOP_CTRL, 32'h0000_0820);
      wt;
      chk({23'h0, fast_irq, vector_valid, vector_num}, {23'h0, 2'b10, 7'h0});
      w(`MIC_OFS_TOP_CTRL, 32'h0000_8620);
      wt;
      chk({23'h0, fast_irq, vector_valid, vector_num}, {23'h0, 2'b10, 7'h0});
      w(`MIC_OFS_TOP_CTRL, 32'h0000_8820);
      w(`MIC_OFS_FST_EN, 32'h0);
      wt;
      chk({23'h0, fast_irq, vector_valid, vector_num}, 32'h0);
      drv(25'h0);
      w(`MIC_OFS_TOP_CTRL, 32'h0);
   endtask
   task t_edge;
      @(posedge clk);
      esel <= 8'h01;
      drv(25'h1 << 17);
      drv(25'h0);
      rc(`MIC_OFS_SOURCE, 32'h0000_0027);
      @(posedge clk);
      eclr <= 8'h01;
      @(posedge clk);
      eclr <= 8'h00;
      rc(`MIC_OFS_SOURCE, 32'h7);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #500000;
      mismatches++;
      wrap_up;
   end
   initial begin
      rst_n = 1'b0;
      s = 25'h0;
      esel = 8'h0;
      eclr = 8'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_map;
      t_enable;
      t_soft;
      t_vector;
      t_edge;
      wrap_up;
   end
endmodule // mcu_interrupt_controller_tb_top
